//--- shared/flash_ctl_pkg.sv
// shared constants, field layout and state codes of the flash led mode controller
package flash_ctl_pkg;

	// register offsets
	localparam logic [7:0] ADR_ENABLE = 8'h01;
	localparam logic [7:0] ADR_MONITOR = 8'h02;
	localparam logic [7:0] ADR_FLASH_BR = 8'h03;
	localparam logic [7:0] ADR_TORCH_BR = 8'h05;
	localparam logic [7:0] ADR_TIMING = 8'h08;
	localparam logic [7:0] ADR_FIRST_FAULT_FLAGS = 8'h0a;
	localparam logic [7:0] ADR_SECOND_FAULT_FLAGS = 8'h0b;

	// field positions
	localparam int EN_MODE_LSB = 0;
	localparam int EN_TORCH_BIT = 2;
	localparam int EN_STROBE_BIT = 3;
	localparam int EN_TEMP_BIT = 4;
	localparam int EN_TX_BIT = 7;
	localparam int MON_HYST_BIT = 2;
	localparam int MON_THR_LSB = 3;
	localparam int MON_MODE_LSB = 6;
	localparam int TIM_TO_LSB = 0;
	localparam int TIM_RAMP_LSB = 4;
	localparam int FL1_TIMEOUT_BIT = 0;
	localparam int FL2_MON_BIT = 2;

	// reset values
	localparam logic [7:0] EN_RST = 8'h80;
	localparam logic [7:0] MON_RST = 8'h00;
	localparam logic [5:0] FLASH_BR_RST = 6'h00;
	localparam logic [5:0] TORCH_BR_RST = 6'h00;
	localparam logic [7:0] TIMING_RST = 8'h1a;

	// mode bit codes and supply monitor modes
	localparam logic [1:0] MB_EXT = 2'b00;
	localparam logic [1:0] MB_IR = 2'b01;
	localparam logic [1:0] MB_TORCH = 2'b10;
	localparam logic [1:0] MB_FLASH = 2'b11;
	localparam logic [1:0] MON_OFF = 2'b00;
	localparam logic [1:0] MON_HOLD = 2'b01;
	localparam logic [1:0] MON_DOWN = 2'b10;
	localparam logic [1:0] MON_UPDN = 2'b11;

	// timing
	localparam int CLK_PERIOD_NS = 50;
	localparam int STEP_TIME_NS = 8000;
	localparam int STEP_CYC = (STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int MS_TIME_NS = 1000000;
	localparam int TO_MIN_MS = 40;
	localparam int TO_STEP_MS = 104;

	typedef enum logic [1:0] {
		LED_OFF = 2'b00,
		LED_FLASH = 2'b01,
		LED_TORCH = 2'b10,
		LED_IR = 2'b11
	} led_state_type;

	typedef enum logic [2:0] {
		BUS_IDLE = 3'b000,
		BUS_ADDR = 3'b001,
		BUS_PTR = 3'b010,
		BUS_WRITE = 3'b011,
		BUS_READ = 3'b100
	} bus_state_type;

endpackage

//--- verilog/scl_byte_capture.sv
// serial data capture running on the serial port clock
`timescale 1ns/10ps
module scl_byte_capture (
	input wire logic scl_clk_i, // serial clock from the host
	input wire logic sda_i, // serial data pin level
	output logic [7:0] byte_o // last eight bits seen, msb first
);

	typedef struct packed {
		logic [7:0] sh;
	} cap_type;

	cap_type c;
	cap_type c_nxt;

	// data only, no control: the clock stops between frames so no reset is needed here
	always_comb begin
		c_nxt = c;
		c_nxt.sh = {c.sh[6:0], sda_i};
	end

	always_ff @(posedge scl_clk_i) begin
		c <= c_nxt;
	end

	assign byte_o = c.sh;

endmodule

//--- verilog/flash_led_mode_controller.sv
// flash led mode, current ramp and serial register control
`timescale 1ns/10ps
module flash_led_mode_controller #(
	parameter logic [6:0] DEV_ADDR = 7'h30, // arbitrary serial address
	parameter int MS_CYCLES = flash_ctl_pkg::MS_TIME_NS / flash_ctl_pkg::CLK_PERIOD_NS
) (
	input wire logic clk_i, // core clock, 20 MHz
	input wire logic rst_b_i, // synchronous reset, active low
	input wire logic hw_enable_pin_i, // hardware enable pin
	input wire logic scl_i, // serial clock pin
	input wire logic sda_i, // serial data pin level
	output logic sda_o, // serial data drive value, always low
	output logic sda_oe_o, // serial data pull-down enable
	input wire logic strobe_pin_i, // hardware flash strobe
	input wire logic torch_pin_i, // hardware torch pin
	input wire logic tx_sync_pin_i, // transmit-sync pin
	input wire logic supply_below_i, // supply below monitor threshold
	input wire logic supply_above_i, // supply above threshold plus hysteresis
	output logic [5:0] led_level_o, // current level code
	output logic led_on_o, // current source on
	output logic flash_scale_o, // 1 flash scale, 0 torch scale
	output logic pass_mode_o, // converter held in pass mode
	output logic [2:0] mon_thresh_o, // monitor threshold select
	output logic mon_hyst_o // monitor hysteresis enable
);

	// indices of the synchronised pin vector
	localparam int P_SCL = 7;
	localparam int P_SDA = 6;
	localparam int P_HW = 5;
	localparam int P_STB = 4;
	localparam int P_TRC = 3;
	localparam int P_TX = 2;
	localparam int P_BLW = 1;
	localparam int P_ABV = 0;

	typedef struct packed {
		logic [7:0] sy0;
		logic [7:0] sy1;
		logic [7:0] sy2;
		flash_ctl_pkg::bus_state_type bst;
		logic [3:0] cnt;
		logic [7:0] ptr;
		logic [7:0] rsh;
		logic oe;
		logic [7:0] en;
		logic [7:0] mon;
		logic [5:0] flash_b;
		logic [5:0] torch_b;
		logic [7:0] timing;
		logic [7:0] first_fault_flags;
		logic [7:0] second_fault_flags;
		flash_ctl_pkg::led_state_type led;
		logic int_src;
		logic [5:0] lvl;
		logic [7:0] stp;
		logic [2:0] rdiv;
		logic [15:0] pre;
		logic [10:0] ms;
		logic hold;
		logic no_raise;
		logic o_on;
		logic o_flash;
		logic o_pass;
		logic [5:0] o_lvl;
	} state_type;

	state_type s;
	state_type n;
	logic [7:0] link_byte;
	logic [7:0] rd_val;
	logic wr_fire;
	logic scl_rise;
	logic scl_fall;
	logic start_c;
	logic stop_c;
	logic step_tick;
	logic torch_tick;
	logic to_hit;
	logic [10:0] to_lim;
	logic below;
	logic above;
	logic ir_on;
	logic tx_on;
	logic [1:0] mm;

	// serial bits are shifted on the link's own clock
	scl_byte_capture u_cap (
		.scl_clk_i(scl_i),
		.sda_i(sda_i),
		.byte_o(link_byte)
	);

	// edges and levels taken only from the second and third sync stages
	assign scl_rise = s.sy1[P_SCL] & ~s.sy2[P_SCL];
	assign scl_fall = ~s.sy1[P_SCL] & s.sy2[P_SCL];
	assign start_c = s.sy1[P_SCL] & s.sy2[P_SCL] & ~s.sy1[P_SDA] & s.sy2[P_SDA];
	assign stop_c = s.sy1[P_SCL] & s.sy2[P_SCL] & s.sy1[P_SDA] & ~s.sy2[P_SDA];
	assign step_tick = s.stp == 8'(flash_ctl_pkg::STEP_CYC - 1);
	assign torch_tick = step_tick && (s.rdiv == s.timing[flash_ctl_pkg::TIM_RAMP_LSB +: 3]);
	assign to_lim = 11'(flash_ctl_pkg::TO_MIN_MS)
		+ 11'(s.timing[flash_ctl_pkg::TIM_TO_LSB +: 4]) * 11'(flash_ctl_pkg::TO_STEP_MS);
	assign to_hit = s.ms >= to_lim;
	assign below = s.sy1[P_BLW];
	// without hysteresis the release point is the threshold itself
	assign above = s.mon[flash_ctl_pkg::MON_HYST_BIT] ? s.sy1[P_ABV] : ~s.sy1[P_BLW];
	assign mm = s.mon[flash_ctl_pkg::MON_MODE_LSB +: 2];

	// read mux
	always_comb begin
		unique case (s.ptr)
			flash_ctl_pkg::ADR_ENABLE: rd_val = s.en;
			flash_ctl_pkg::ADR_MONITOR: rd_val = s.mon;
			flash_ctl_pkg::ADR_FLASH_BR: rd_val = {2'b00, s.flash_b};
			flash_ctl_pkg::ADR_TORCH_BR: rd_val = {2'b00, s.torch_b};
			flash_ctl_pkg::ADR_TIMING: rd_val = s.timing;
			flash_ctl_pkg::ADR_FIRST_FAULT_FLAGS: rd_val = s.first_fault_flags;
			flash_ctl_pkg::ADR_SECOND_FAULT_FLAGS: rd_val = s.second_fault_flags;
			default: rd_val = 8'h00;
		endcase
	end

	// next state
	always_comb begin
		n = s;
		wr_fire = 1'b0;
		ir_on = 1'b0;
		tx_on = 1'b0;
		n.sy0 = {scl_i, sda_i, hw_enable_pin_i, strobe_pin_i, torch_pin_i,
			tx_sync_pin_i, supply_below_i, supply_above_i};
		n.sy1 = s.sy0;
		n.sy2 = s.sy1;

		// serial port: start and stop win over everything else
		if (start_c) begin
			n.bst = flash_ctl_pkg::BUS_ADDR;
			n.cnt = 4'h0;
			n.oe = 1'b0;
		end else if (stop_c) begin
			n.bst = flash_ctl_pkg::BUS_IDLE;
			n.oe = 1'b0;
		end else if (s.bst != flash_ctl_pkg::BUS_IDLE) begin
			if (scl_rise) begin
				n.cnt = s.cnt + 4'h1;
				// master leaves data high on the ninth bit: read is over
				if (s.cnt == 4'h8 && s.bst == flash_ctl_pkg::BUS_READ && s.sy1[P_SDA]) begin
					n.bst = flash_ctl_pkg::BUS_IDLE;
				end
			end
			if (scl_fall) begin
				// link byte is stable here: it changes only on the next scl rise
				if (s.cnt == 4'h8) begin
					n.oe = 1'b1;
					unique case (s.bst)
						flash_ctl_pkg::BUS_ADDR: begin
							if (link_byte[7:1] != DEV_ADDR) begin
								n.bst = flash_ctl_pkg::BUS_IDLE;
								n.oe = 1'b0;
							end else if (link_byte[0]) begin
								n.bst = flash_ctl_pkg::BUS_READ;
							end else begin
								n.bst = flash_ctl_pkg::BUS_PTR;
							end
						end
						flash_ctl_pkg::BUS_PTR: begin
							n.ptr = link_byte;
							n.bst = flash_ctl_pkg::BUS_WRITE;
						end
						flash_ctl_pkg::BUS_WRITE: begin
							wr_fire = 1'b1;
						end
						flash_ctl_pkg::BUS_READ: begin
							n.oe = 1'b0;
						end
						default: begin
							n.bst = flash_ctl_pkg::BUS_IDLE;
							n.oe = 1'b0;
						end
					endcase
				end else if (s.cnt == 4'h9) begin
					n.cnt = 4'h0;
					n.oe = 1'b0;
					if (s.bst == flash_ctl_pkg::BUS_READ) begin
						n.oe = ~rd_val[7];
						n.rsh = {rd_val[6:0], 1'b0};
						// flags clear on read; hardware sets below still win
						if (s.ptr == flash_ctl_pkg::ADR_FIRST_FAULT_FLAGS) begin
							n.first_fault_flags = 8'h00;
						end
						if (s.ptr == flash_ctl_pkg::ADR_SECOND_FAULT_FLAGS) begin
							n.second_fault_flags = 8'h00;
						end
					end
				end else if (s.bst == flash_ctl_pkg::BUS_READ) begin
					n.oe = ~s.rsh[7];
					n.rsh = {s.rsh[6:0], 1'b0};
				end
			end
		end

		// register writes
		if (wr_fire) begin
			unique case (s.ptr)
				flash_ctl_pkg::ADR_ENABLE: n.en = link_byte;
				flash_ctl_pkg::ADR_MONITOR: n.mon = link_byte;
				flash_ctl_pkg::ADR_FLASH_BR: n.flash_b = link_byte[5:0];
				flash_ctl_pkg::ADR_TORCH_BR: n.torch_b = link_byte[5:0];
				flash_ctl_pkg::ADR_TIMING: n.timing = link_byte;
				default: n.timing = n.timing;
			endcase
		end

		// free running step interval and torch ramp divider
		n.stp = step_tick ? 8'h00 : s.stp + 8'h01;
		if (step_tick) begin
			n.rdiv = torch_tick ? 3'h0 : s.rdiv + 3'h1;
		end
		// event timer in ms, runs in flash and ir
		if (s.pre == 16'(MS_CYCLES - 1)) begin
			n.pre = 16'h0000;
			n.ms = s.ms + 11'h001;
		end else begin
			n.pre = s.pre + 16'h0001;
		end
		// supply crossing below the threshold
		if (s.sy1[P_BLW] && !s.sy2[P_BLW]) begin
			n.second_fault_flags[flash_ctl_pkg::FL2_MON_BIT] = 1'b1;
		end

		// led mode state machine
		unique case (s.led)
			flash_ctl_pkg::LED_OFF: begin
				n.lvl = 6'h00;
				n.pre = 16'h0000;
				n.ms = 11'h000;
				n.hold = 1'b0;
				n.no_raise = 1'b0;
				if (n.en[1:0] == flash_ctl_pkg::MB_FLASH) begin
					n.led = flash_ctl_pkg::LED_FLASH;
					n.int_src = 1'b1;
				end else if (n.en[1:0] == flash_ctl_pkg::MB_TORCH) begin
					n.led = flash_ctl_pkg::LED_TORCH;
					n.int_src = 1'b1;
				end else if (n.en[1:0] == flash_ctl_pkg::MB_IR) begin
					n.led = flash_ctl_pkg::LED_IR;
					n.int_src = 1'b0;
				end else if (n.en[flash_ctl_pkg::EN_STROBE_BIT]
					&& s.sy1[P_STB] && !s.sy2[P_STB]) begin
					n.led = flash_ctl_pkg::LED_FLASH;
					n.int_src = 1'b0;
				end else if (n.en[flash_ctl_pkg::EN_TORCH_BIT] && !n.en[flash_ctl_pkg::EN_TEMP_BIT]
					&& s.sy1[P_TRC] && !s.sy2[P_TRC]) begin
					n.led = flash_ctl_pkg::LED_TORCH;
					n.int_src = 1'b0;
				end
			end
			flash_ctl_pkg::LED_FLASH: begin
				if (to_hit) begin
					n.led = flash_ctl_pkg::LED_OFF;
					n.en[1:0] = flash_ctl_pkg::MB_EXT;
					n.first_fault_flags[flash_ctl_pkg::FL1_TIMEOUT_BIT] = 1'b1;
				end else if (s.int_src ? (n.en[1:0] != flash_ctl_pkg::MB_FLASH)
					: (n.en[1:0] != flash_ctl_pkg::MB_EXT || !s.sy1[P_STB]
					|| !n.en[flash_ctl_pkg::EN_STROBE_BIT])) begin
					n.led = flash_ctl_pkg::LED_OFF;
				end else begin
					if (below) begin
						n.hold = 1'b1;
					end
					if (step_tick) begin
						// one level per interval in every direction
						if (s.lvl > s.flash_b) begin
							n.lvl = s.lvl - 6'h01;
						end else begin
							unique case (mm)
								flash_ctl_pkg::MON_OFF: begin
									if (s.lvl < s.flash_b) n.lvl = s.lvl + 6'h01;
								end
								flash_ctl_pkg::MON_HOLD: begin
									if (!s.hold && !below && s.lvl < s.flash_b) begin
										n.lvl = s.lvl + 6'h01;
									end
								end
								flash_ctl_pkg::MON_DOWN: begin
									if (below) begin
										n.no_raise = 1'b1;
										if (s.lvl != 6'h00) n.lvl = s.lvl - 6'h01;
									end else if (!s.no_raise && s.lvl < s.flash_b) begin
										n.lvl = s.lvl + 6'h01;
									end
								end
								flash_ctl_pkg::MON_UPDN: begin
									if (below) begin
										if (s.lvl != 6'h00) n.lvl = s.lvl - 6'h01;
									end else if (above && s.lvl < s.flash_b) begin
										n.lvl = s.lvl + 6'h01;
									end
								end
							endcase
						end
					end
				end
			end
			flash_ctl_pkg::LED_TORCH: begin
				// timer kept clear: timeout and transmit-sync do not touch torch
				n.ms = 11'h000;
				if (s.int_src ? (n.en[1:0] != flash_ctl_pkg::MB_TORCH)
					: (n.en[1:0] != flash_ctl_pkg::MB_EXT || !s.sy1[P_TRC]
					|| !n.en[flash_ctl_pkg::EN_TORCH_BIT] || n.en[flash_ctl_pkg::EN_TEMP_BIT])) begin
					n.led = flash_ctl_pkg::LED_OFF;
				end else if (torch_tick) begin
					if (s.lvl < s.torch_b) begin
						n.lvl = s.lvl + 6'h01;
					end else if (s.lvl > s.torch_b) begin
						n.lvl = s.lvl - 6'h01;
					end
				end
			end
			flash_ctl_pkg::LED_IR: begin
				if (n.en[1:0] != flash_ctl_pkg::MB_IR) begin
					n.led = flash_ctl_pkg::LED_OFF;
				end else if (!(s.en[flash_ctl_pkg::EN_STROBE_BIT] && s.sy1[P_STB])) begin
					n.pre = 16'h0000; // each strobe pulse is one bounded event
					n.ms = 11'h000;
				end else if (to_hit) begin
					n.led = flash_ctl_pkg::LED_OFF;
					n.en[1:0] = flash_ctl_pkg::MB_EXT;
					n.first_fault_flags[flash_ctl_pkg::FL1_TIMEOUT_BIT] = 1'b1;
				end
			end
		endcase

		// registered outputs follow the next state
		ir_on = n.en[flash_ctl_pkg::EN_STROBE_BIT] && s.sy1[P_STB];
		tx_on = n.en[flash_ctl_pkg::EN_TX_BIT] && s.sy1[P_TX];
		n.o_on = 1'b0;
		n.o_flash = 1'b0;
		n.o_pass = 1'b0;
		n.o_lvl = 6'h00;
		unique case (n.led)
			flash_ctl_pkg::LED_OFF: n.o_on = 1'b0;
			flash_ctl_pkg::LED_FLASH: begin
				n.o_on = 1'b1;
				n.o_flash = !tx_on;
				n.o_lvl = tx_on ? n.torch_b : n.lvl;
			end
			flash_ctl_pkg::LED_TORCH: begin
				n.o_on = 1'b1;
				n.o_lvl = n.lvl;
			end
			flash_ctl_pkg::LED_IR: begin
				n.o_on = ir_on;
				n.o_flash = 1'b1;
				n.o_pass = 1'b1;
				n.o_lvl = n.flash_b;
			end
		endcase

		// enable pin low holds everything here at defaults, only the pin sync and the u_cap serial shift register keep running
		if (!s.sy1[P_HW]) begin
			n = '0;
			n.sy0 = {scl_i, sda_i, hw_enable_pin_i, strobe_pin_i, torch_pin_i,
				tx_sync_pin_i, supply_below_i, supply_above_i};
			n.sy1 = s.sy0;
			n.sy2 = s.sy1;
			n.en = flash_ctl_pkg::EN_RST;
			n.mon = flash_ctl_pkg::MON_RST;
			n.flash_b = flash_ctl_pkg::FLASH_BR_RST;
			n.torch_b = flash_ctl_pkg::TORCH_BR_RST;
			n.timing = flash_ctl_pkg::TIMING_RST;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			s <= '0;
			s.en <= flash_ctl_pkg::EN_RST;
			s.mon <= flash_ctl_pkg::MON_RST;
			s.flash_b <= flash_ctl_pkg::FLASH_BR_RST;
			s.torch_b <= flash_ctl_pkg::TORCH_BR_RST;
			s.timing <= flash_ctl_pkg::TIMING_RST;
		end else begin
			s <= n;
		end
	end

	assign sda_o = 1'b0;
	assign sda_oe_o = s.oe;
	assign led_level_o = s.o_lvl;
	assign led_on_o = s.o_on;
	assign flash_scale_o = s.o_flash;
	assign pass_mode_o = s.o_pass;
	assign mon_thresh_o = s.mon[flash_ctl_pkg::MON_THR_LSB +: 3];
	assign mon_hyst_o = s.mon[flash_ctl_pkg::MON_HYST_BIT];

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_b_i);

	sequence q_wr_flash;
		wr_fire && s.ptr == flash_ctl_pkg::ADR_ENABLE && link_byte[1:0] == flash_ctl_pkg::MB_FLASH;
	endsequence
	sequence q_flash_expire;
		s.led == flash_ctl_pkg::LED_FLASH && to_hit && s.sy1[P_HW];
	endsequence

	property p_hw_enable_pin_off;
		!s.sy1[P_HW] |=> s.led == flash_ctl_pkg::LED_OFF && s.en == flash_ctl_pkg::EN_RST
			&& s.bst == flash_ctl_pkg::BUS_IDLE ##1 !led_on_o && !sda_oe_o;
	endproperty
	a_hw_enable_pin_off: assert property (p_hw_enable_pin_off) else $error("enable low did not shut down");

	property p_flash_start;
		q_wr_flash ##0 (s.led == flash_ctl_pkg::LED_OFF && s.sy1[P_HW]) |=>
			s.led == flash_ctl_pkg::LED_FLASH && led_on_o && flash_scale_o == !$past(tx_on);
	endproperty
	a_flash_start: assert property (p_flash_start) else $error("flash did not start");

	property p_ramp_step;
		(s.led == flash_ctl_pkg::LED_FLASH && $past(s.led) == flash_ctl_pkg::LED_FLASH) |->
			(s.lvl == $past(s.lvl) || s.lvl == $past(s.lvl) + 6'h01 || s.lvl == $past(s.lvl) - 6'h01);
	endproperty
	a_ramp_step: assert property (p_ramp_step) else $error("flash level jumped");

	property p_timeout;
		q_flash_expire |=> s.en[1:0] == flash_ctl_pkg::MB_EXT
			&& s.first_fault_flags[flash_ctl_pkg::FL1_TIMEOUT_BIT] && !led_on_o;
	endproperty
	a_timeout: assert property (p_timeout) else $error("timeout did not end the flash");

	property p_torch_holds;
		(s.led == flash_ctl_pkg::LED_TORCH && s.int_src && s.en[1:0] == flash_ctl_pkg::MB_TORCH
			&& !wr_fire && s.sy1[P_HW]) |=> s.led == flash_ctl_pkg::LED_TORCH && led_on_o
			&& !flash_scale_o;
	endproperty
	a_torch_holds: assert property (p_torch_holds) else $error("torch disturbed");

	property p_ir_gate;
		(s.led == flash_ctl_pkg::LED_IR && s.en[1:0] == flash_ctl_pkg::MB_IR && !wr_fire
			&& !to_hit && s.sy1[P_HW]) |=> led_on_o == (s.en[flash_ctl_pkg::EN_STROBE_BIT]
			&& $past(s.sy1[P_STB])) && pass_mode_o && led_level_o == s.flash_b;
	endproperty
	a_ir_gate: assert property (p_ir_gate) else $error("ir current not gated by strobe");

	property p_tx_drop;
		(s.led == flash_ctl_pkg::LED_FLASH && s.en[flash_ctl_pkg::EN_TX_BIT] && s.sy1[P_TX]
			&& !to_hit && !wr_fire && s.sy1[P_HW] && s.int_src && s.en[1:0] == flash_ctl_pkg::MB_FLASH)
			|=> led_level_o == s.torch_b && !flash_scale_o && led_on_o;
	endproperty
	a_tx_drop: assert property (p_tx_drop) else $error("transmit-sync did not drop current");

	property p_tx_ignored;
		(s.led == flash_ctl_pkg::LED_FLASH && !s.en[flash_ctl_pkg::EN_TX_BIT] && !wr_fire)
			##1 s.led == flash_ctl_pkg::LED_FLASH |-> led_level_o == s.lvl && flash_scale_o;
	endproperty
	a_tx_ignored: assert property (p_tx_ignored) else $error("disabled transmit-sync acted");

	property p_hold;
		(s.led == flash_ctl_pkg::LED_FLASH && mm == flash_ctl_pkg::MON_HOLD && s.hold
			&& s.lvl <= s.flash_b) |=> s.lvl <= $past(s.lvl);
	endproperty
	a_hold: assert property (p_hold) else $error("ramp went on after hold");

	property p_no_raise;
		(s.led == flash_ctl_pkg::LED_FLASH && mm == flash_ctl_pkg::MON_DOWN && s.no_raise)
			|=> s.lvl <= $past(s.lvl) || s.led != flash_ctl_pkg::LED_FLASH;
	endproperty
	a_no_raise: assert property (p_no_raise) else $error("down mode raised current");

	property p_mon_flag;
		(s.sy1[P_BLW] && !s.sy2[P_BLW] && s.sy1[P_HW]) |=> s.second_fault_flags[flash_ctl_pkg::FL2_MON_BIT];
	endproperty
	a_mon_flag: assert property (p_mon_flag) else $error("monitor flag not set");

	property p_flash_first;
		(s.led == flash_ctl_pkg::LED_OFF && s.en[1:0] == flash_ctl_pkg::MB_EXT && !wr_fire
			&& s.en[flash_ctl_pkg::EN_STROBE_BIT] && s.sy1[P_STB] && !s.sy2[P_STB] && s.sy1[P_HW])
			|=> s.led == flash_ctl_pkg::LED_FLASH && !s.int_src;
	endproperty
	a_flash_first: assert property (p_flash_first) else $error("strobe edge lost priority");

endmodule

//--- test/host_model.sv
// serial host model driving the register port clock and data lines
`timescale 1ns/10ps
module host_model (
	input wire logic sda_line_i, // resolved data line level
	output logic scl_o, // serial clock to the device
	output logic sda_o // data drive, 1 releases the line to its pull-up
);
	localparam int HALF = 1300; // each phase well above four core clocks
	// idle bus: both lines released high
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	// start or repeated start: data falls while the clock is high
	task automatic start();
		#(HALF / 2) sda_o = 1'b1;
		#(HALF / 2) scl_o = 1'b1;
		#HALF sda_o = 1'b0;
		#HALF scl_o = 1'b0;
	endtask
	// stop: data rises while the clock is high
	task automatic stop();
		#(HALF / 2) sda_o = 1'b0;
		#(HALF / 2) scl_o = 1'b1;
		#HALF sda_o = 1'b1;
		#HALF;
	endtask
	// eight bits msb first, then the acknowledge bit; data moves mid low phase to avoid
	// a false start or stop when both lines pass the core clock synchronisers together
	task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
		output logic ack);
		for (int i = 8; i >= 0; i--) begin
			#(HALF / 2) sda_o = (i > 0) ? tx[i - 1] : ack_in;
			#(HALF / 2) scl_o = 1'b1;
			#HALF;
			if (i > 0) begin
				rx[i - 1] = sda_line_i;
			end else begin
				ack = ~sda_line_i;
			end
			scl_o = 1'b0;
		end
	endtask
endmodule

//--- test/tb_top.sv
// self-checking bench: serial register access, led modes and pin control
`timescale 1ns/10ps
module tb_top;
	localparam logic [6:0] DEV = 7'h30;
	logic clk_i = 1'b0, rst_b_i = 1'b0, hw_en = 1'b1, strobe = 1'b0, torch = 1'b0, tx = 1'b0;
	logic blw = 1'b0, abv = 1'b1;
	logic scl, host_sda, sda_line, sda_d, sda_oe, led_on, fscale, pass, hyst;
	logic [5:0] level;
	logic [2:0] thr;
	int num_errors = 0, num_checks = 0, cycles = 0;
	// open-drain data line: pulled up unless someone pulls it low
	assign sda_line = sda_oe ? sda_d : host_sda;
	host_model host (.sda_line_i(sda_line), .scl_o(scl), .sda_o(host_sda));
	flash_led_mode_controller #(.MS_CYCLES(20)) dut (.clk_i(clk_i), .rst_b_i(rst_b_i),
		.hw_enable_pin_i(hw_en), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_d),
		.sda_oe_o(sda_oe), .strobe_pin_i(strobe), .torch_pin_i(torch), .tx_sync_pin_i(tx),
		.supply_below_i(blw), .supply_above_i(abv), .led_level_o(level), .led_on_o(led_on),
		.flash_scale_o(fscale), .pass_mode_o(pass), .mon_thresh_o(thr), .mon_hyst_o(hyst));
	// core clock, 20 MHz
	initial begin
		forever #25 clk_i = ~clk_i;
	end
	task automatic close_out();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// hang guard, some thirty thousand cycles above the nearly sixty thousand the tests need
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 90000) begin
			num_errors++;
			close_out();
		end
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// inputs always move 5 ns after a rising edge
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
		#5;
	endtask
	// bounded wait for led state {on, flash scale, level} under a mask
	task automatic wt(input logic [7:0] e, input logic [7:0] m, input int n);
		for (int i = 0; i < n && ({led_on, fscale, level} & m) !== e; i++)
			cyc(1);
		chk({led_on, fscale, level} & m, e);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] r;
		logic k0, k1, k2;
		host.start();
		host.xfer({DEV, 1'b0}, 1'b1, r, k0);
		host.xfer(a, 1'b1, r, k1);
		host.xfer(d, 1'b1, r, k2);
		host.stop();
		chk({5'h00, k0, k1, k2}, 8'h07);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] r;
		logic k;
		host.start();
		host.xfer({DEV, 1'b0}, 1'b1, r, k);
		host.xfer(a, 1'b1, r, k);
		host.start();
		host.xfer({DEV, 1'b1}, 1'b1, r, k);
		host.xfer(8'hff, 1'b1, r, k);
		host.stop();
		chk(r, e);
	endtask
	// main sequence
	initial begin
		cyc(6);
		rst_b_i = 1'b1;
		cyc(40);
		rd(8'h01, 8'h80);
		rd(8'h08, 8'h1a);
		rd(8'h04, 8'h00);
		wr(8'h02, 8'h2c);
		chk({4'h0, thr, hyst}, 8'h0b);
		$display("test registers done");
		wr(8'h03, 8'h03);
		wr(8'h05, 8'h05);
		wr(8'h08, 8'h11);
		wr(8'h01, 8'h83);
		wt(8'hc1, 8'hff, 200);
		wt(8'hc2, 8'hff, 200);
		wt(8'hc3, 8'hff, 200);
		tx = 1'b1;
		wt(8'h85, 8'hff, 10);
		tx = 1'b0;
		wt(8'hc3, 8'hff, 10);
		tx = 1'b1;
		wt(8'h00, 8'h80, 3000);
		rd(8'h01, 8'h80);
		rd(8'h0a, 8'h01);
		rd(8'h0a, 8'h00);
		$display("test register flash done");
		wr(8'h01, 8'h82);
		for (int v = 1; v <= 5; v++)
			wt(8'h80 | 8'(v), 8'hff, 400);
		cyc(3000);
		wt(8'h85, 8'hff, 1);
		$display("test torch done");
		wr(8'h01, 8'h08);
		cyc(1);
		strobe = 1'b1;
		wt(8'hc3, 8'hff, 700);
		strobe = 1'b0;
		wt(8'h00, 8'h80, 10);
		tx = 1'b0;
		wr(8'h01, 8'h0c);
		cyc(1);
		strobe = 1'b1;
		torch = 1'b1;
		wt(8'hc1, 8'hff, 200);
		strobe = 1'b0;
		torch = 1'b0;
		wt(8'h00, 8'h80, 10);
		cyc(1);
		torch = 1'b1;
		wt(8'h81, 8'hff, 400);
		torch = 1'b0;
		wt(8'h00, 8'h80, 10);
		$display("test pins done");
		wr(8'h01, 8'h09);
		chk({7'h00, pass}, 8'h01);
		strobe = 1'b1;
		wt(8'h80, 8'h80, 10);
		chk({led_on, fscale, level}, 8'hc3);
		strobe = 1'b0;
		wt(8'h00, 8'h80, 10);
		$display("test ir done");
		// supply monitor: hold, down, then up-and-down with hysteresis, one flash each
		wr(8'h02, 8'h6c);
		wr(8'h01, 8'h83);
		chk({7'h00, pass}, 8'h00);
		wt(8'hc1, 8'hff, 200);
		blw = 1'b1;
		cyc(10);
		blw = 1'b0;
		cyc(400);
		wt(8'hc1, 8'hff, 1);
		wt(8'h00, 8'h80, 3000);
		rd(8'h0b, 8'h04);
		wr(8'h02, 8'hac);
		wr(8'h01, 8'h83);
		wt(8'hc3, 8'hff, 700);
		blw = 1'b1;
		wt(8'hc2, 8'hff, 200);
		blw = 1'b0;
		cyc(400);
		wt(8'hc2, 8'hff, 1);
		wt(8'h00, 8'h80, 3000);
		wr(8'h02, 8'hec);
		wr(8'h01, 8'h83);
		wt(8'hc3, 8'hff, 700);
		blw = 1'b1;
		abv = 1'b0;
		wt(8'hc2, 8'hff, 200);
		wt(8'hc1, 8'hff, 200);
		blw = 1'b0;
		cyc(400);
		wt(8'hc1, 8'hff, 1);
		abv = 1'b1;
		wt(8'hc2, 8'hff, 200);
		wt(8'hc3, 8'hff, 200);
		wt(8'h00, 8'h80, 3000);
		$display("test supply monitor done");
		hw_en = 1'b0;
		cyc(5);
		chk({4'h0, thr, hyst}, 8'h00);
		hw_en = 1'b1;
		cyc(40);
		rd(8'h02, 8'h00);
		$display("test enable pin done");
		close_out();
	end
endmodule
